/* File: bench/gsr_ctrl_model.sv */
// Remote controller model that issues decoded commands to the status core
`timescale 1ns/1ps
`default_nettype none

module gsr_ctrl_model
    import gsr_pkg::*;
(
    // Clock
    input wire logic clk_sys_in,
    // Command drive
    output var logic cmd_valid_out,
    output var gsr_cmd_e cmd_code_out,
    output var logic [7:0] cmd_arg_out,
    output var logic cmd_from_gpib_out,
    // Answers
    input wire logic rsp_valid_in,
    input wire logic [7:0] rsp_data_in,
    input wire logic cmd_reject_in
);
    initial
    begin
        cmd_valid_out = 1'b0;
        cmd_code_out = GSR_CMD_WAI;
        cmd_arg_out = 8'h00;
        cmd_from_gpib_out = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Present one command for one edge, then capture the answer
    task automatic issue(input gsr_cmd_e code, input logic [7:0] arg, input logic gpib,
                         output logic got_v, output logic [7:0] got_d, output logic got_r);
        cmd_valid_out = 1'b1;
        cmd_code_out = code;
        cmd_arg_out = arg;
        cmd_from_gpib_out = gpib;
        @(posedge clk_sys_in);
        #1;
        got_v = rsp_valid_in;
        got_d = rsp_data_in;
        got_r = cmd_reject_in;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Release; qualifiers go to the inverse of their last value
    task automatic idle();
        cmd_valid_out = 1'b0;
        cmd_code_out = gsr_cmd_e'(~cmd_code_out);
        cmd_arg_out = ~cmd_arg_out;
        cmd_from_gpib_out = ~cmd_from_gpib_out;
    endtask
endmodule

`default_nettype wire

/* File: bench/tb_gsr_status_core.sv */
// Self-checking testbench of the status reporting core
`timescale 1ns/1ps
`default_nettype none

`define CHK(what, exp, got) \
    begin \
        n_compared++; \
        if ((got) !== (exp)) \
        begin \
            fail_count++; \
            $display("[ERR] %s expected %h seen %h", what, exp, got); \
        end \
    end

module tb_gsr_status_core
    import gsr_pkg::*;
;
    logic clk_sys_in, sys_rst_in, cmd_valid, cmd_from_gpib, rsp_valid, cmd_reject, srq;
    logic query_err, exec_err, cmd_err, rsp_waiting, gpib_enabled;
    logic [7:0] cmd_arg, measurement_condition_register, rsp_data, stb;
    gsr_cmd_e cmd_code;
    int fail_count = 0;
    int n_compared = 0;
    gsr_cmd_e set_c [3] = '{GSR_CMD_ESE_SET, GSR_CMD_SRE_SET, GSR_CMD_MCE_SET};
    gsr_cmd_e qry_c [3] = '{GSR_CMD_ESE_QRY, GSR_CMD_SRE_QRY, GSR_CMD_MCE_QRY};
    logic [7:0] vals [4] = '{8'hff, 8'h5a, 8'h00, 8'h81};

    ////////////////////////////////////////////////////////////////////////////////
    // Design and controller
    gsr_status_core dut_u (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
        .cmd_valid_in(cmd_valid), .cmd_code_in(cmd_code), .cmd_arg_in(cmd_arg),
        .cmd_from_gpib_in(cmd_from_gpib), .query_err_in(query_err), .exec_err_in(exec_err),
        .cmd_err_in(cmd_err), .measurement_condition_register_in(measurement_condition_register),
        .rsp_waiting_in(rsp_waiting), .gpib_enabled_in(gpib_enabled),
        .rsp_valid_out(rsp_valid), .rsp_data_out(rsp_data), .cmd_reject_out(cmd_reject),
        .status_byte_out(stb), .srq_out(srq));

    gsr_ctrl_model ctrl_u (.clk_sys_in(clk_sys_in), .cmd_valid_out(cmd_valid),
        .cmd_code_out(cmd_code), .cmd_arg_out(cmd_arg), .cmd_from_gpib_out(cmd_from_gpib),
        .rsp_valid_in(rsp_valid), .rsp_data_in(rsp_data), .cmd_reject_in(cmd_reject));

    initial
    begin
        clk_sys_in = 1'b0;
        forever #12.5 clk_sys_in = ~clk_sys_in;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask

    task automatic rest(input int n);
        ctrl_u.idle();
        tick(n);
    endtask

    task automatic send(input gsr_cmd_e code, input logic [7:0] arg, input logic gpib,
                        input logic exp_v, input logic [7:0] exp_d, input logic exp_r);
        logic v;
        logic [7:0] d;
        logic r;
        ctrl_u.issue(code, arg, gpib, v, d, r);
        `CHK("answer pulse", exp_v, v)
        if (exp_v)
            `CHK("answer data", exp_d, d)
        `CHK("refusal pulse", exp_r, r)
    endtask

    task automatic chk_stb(input logic [7:0] e);
        `CHK("status byte", e, stb)
        `CHK("service request", e[6], srq)
    endtask

    task automatic tally_and_finish();
        $display("Compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial
    begin
        repeat (5000) @(posedge clk_sys_in);
        fail_count++;
        tally_and_finish();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        sys_rst_in = 1'b1;
        {query_err, exec_err, cmd_err, rsp_waiting, gpib_enabled} = 5'h00;
        measurement_condition_register = 8'h00;
        tick(6);
        sys_rst_in = 1'b0;
        tick(1);
        chk_stb(8'h00);
        send(GSR_CMD_ESR_QRY, 8'h00, 1'b1, 1'b1, 8'h80, 1'b0);
        send(GSR_CMD_ESR_QRY, 8'h00, 1'b1, 1'b1, 8'h00, 1'b0);
        send(GSR_CMD_TST_QRY, 8'h5a, 1'b1, 1'b1, 8'h00, 1'b0);
        foreach (set_c[i])
            foreach (vals[j])
            begin
                send(set_c[i], vals[j], 1'b1, 1'b0, 8'h00, 1'b0);
                send(qry_c[i], 8'h00, 1'b1, 1'b1, vals[j], 1'b0);
                send(qry_c[i], 8'h00, 1'b1, 1'b1, vals[j], 1'b0);
            end
        send(GSR_CMD_WAI, 8'h00, 1'b1, 1'b0, 8'h00, 1'b0);
        send(GSR_CMD_ESE_SET, 8'h3c, 1'b0, 1'b0, 8'h00, 1'b1);
        send(GSR_CMD_OPC, 8'h00, 1'b0, 1'b0, 8'h00, 1'b1);
        send(gsr_cmd_e'(4'hf), 8'h00, 1'b1, 1'b0, 8'h00, 1'b1);
        send(GSR_CMD_ESE_QRY, 8'h00, 1'b1, 1'b1, 8'h81, 1'b0);
        send(GSR_CMD_ESR_QRY, 8'h00, 1'b1, 1'b1, 8'h00, 1'b0);
        send(GSR_CMD_ESE_SET, 8'h01, 1'b1, 1'b0, 8'h00, 1'b0);
        send(GSR_CMD_SRE_SET, 8'h20, 1'b1, 1'b0, 8'h00, 1'b0);
        send(GSR_CMD_OPC, 8'h00, 1'b1, 1'b0, 8'h00, 1'b0);
        rest(2);
        chk_stb(8'h60);
        send(GSR_CMD_STB_QRY, 8'h00, 1'b1, 1'b1, 8'h60, 1'b0);
        send(GSR_CMD_ESR_QRY, 8'h00, 1'b1, 1'b1, 8'h01, 1'b0);
        send(GSR_CMD_ESE_SET, 8'h08, 1'b1, 1'b0, 8'h00, 1'b0);
        rest(2);
        chk_stb(8'h00);
        {exec_err, cmd_err} = 2'h3;
        tick(1);
        {exec_err, cmd_err} = 2'h0;
        tick(2);
        chk_stb(8'h00);
        query_err = 1'b1;
        tick(1);
        query_err = 1'b0;
        tick(2);
        chk_stb(8'h60);
        send(GSR_CMD_ESR_QRY, 8'h00, 1'b1, 1'b1, 8'h38, 1'b0);
        send(GSR_CMD_MCE_SET, 8'h0c, 1'b1, 1'b0, 8'h00, 1'b0);
        send(GSR_CMD_SRE_SET, 8'h01, 1'b1, 1'b0, 8'h00, 1'b0);
        rest(1);
        measurement_condition_register = 8'h04;
        tick(2);
        chk_stb(8'h41);
        measurement_condition_register = 8'h13;
        rsp_waiting = 1'b1;
        tick(2);
        chk_stb(8'h10);
        send(GSR_CMD_SRE_SET, 8'h10, 1'b1, 1'b0, 8'h00, 1'b0);
        rest(2);
        chk_stb(8'h50);
        send(GSR_CMD_SRE_SET, 8'hce, 1'b1, 1'b0, 8'h00, 1'b0);
        rest(2);
        chk_stb(8'h10);
        send(GSR_CMD_STB_QRY, 8'h00, 1'b1, 1'b1, 8'h10, 1'b0);
        rest(1);
        gpib_enabled = 1'b1;
        tick(3);
        send(GSR_CMD_ESR_QRY, 8'h00, 1'b1, 1'b1, 8'h80, 1'b0);
        rest(1);
        sys_rst_in = 1'b1;
        rsp_waiting = 1'b0;
        tick(2);
        chk_stb(8'h00);
        sys_rst_in = 1'b0;
        send(GSR_CMD_ESE_QRY, 8'h00, 1'b1, 1'b1, 8'h00, 1'b0);
        send(GSR_CMD_ESR_QRY, 8'h00, 1'b1, 1'b1, 8'h80, 1'b0);
        rest(2);
        tally_and_finish();
    end
endmodule

`default_nettype wire

/* File: src/gsr_event_latch.sv */
// Sticky event register, set wins over clear-on-read
`timescale 1ns/1ps
`default_nettype none

module gsr_event_latch
    import gsr_pkg::*;
#(
    parameter logic [7:0] RST_VAL = 8'h00
)
(
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    // Set and clear
    input wire logic [7:0] set_in,
    input wire logic clr_in,
    // Contents
    output logic [7:0] bits_out
);

    ////////////////////////////////////////////////////////////////////////////////
    // Next value per bit, set wins over clear
    logic [7:0] bits_nxt;
    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1)
        begin : g_bit
            assign bits_nxt[i] = set_in[i] || (bits_out[i] && !clr_in);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // One register for all bits
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
            bits_out <= RST_VAL;
        else
            bits_out <= bits_nxt;
    end

endmodule

`default_nettype wire

/* File: src/gsr_pkg.sv */
// Constants and types shared by the status reporting logic
package gsr_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Decoded remote commands
    typedef enum logic [3:0] {
        GSR_CMD_WAI,
        GSR_CMD_ESE_SET,
        GSR_CMD_ESE_QRY,
        GSR_CMD_OPC,
        GSR_CMD_SRE_SET,
        GSR_CMD_SRE_QRY,
        GSR_CMD_STB_QRY,
        GSR_CMD_TST_QRY,
        GSR_CMD_MCE_SET,
        GSR_CMD_MCE_QRY,
        GSR_CMD_ESR_QRY
    } gsr_cmd_e;

    ////////////////////////////////////////////////////////////////////////////////
    // Event status register bit positions
    localparam int unsigned ESR_OPC_BIT = 0;
    localparam int unsigned ESR_QUERY_ERR_BIT = 3;
    localparam int unsigned ESR_EXEC_ERR_BIT = 4;
    localparam int unsigned ESR_CMD_ERR_BIT = 5;
    localparam int unsigned ESR_POWER_ON_BIT = 7;

    ////////////////////////////////////////////////////////////////////////////////
    // Status byte bit positions
    localparam int unsigned STB_MEAS_BIT = 0;
    localparam int unsigned STB_RSP_BIT = 4;
    localparam int unsigned STB_EVENT_BIT = 5;
    localparam int unsigned STB_MSS_BIT = 6;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values and fixed answers
    localparam logic [7:0] ESE_RST = 8'h00;
    localparam logic [7:0] SRE_RST = 8'h00;
    localparam logic [7:0] MCE_RST = 8'h00;
    localparam logic [7:0] ESR_RST = 8'h80;
    localparam logic [7:0] STB_RST = 8'h00;
    localparam logic [7:0] RSP_RST = 8'h00;
    localparam logic [7:0] SELF_TEST_RESULT = 8'h00;

endpackage

/* File: src/gsr_status_core.sv */
// Status reporting and service request logic of the remote interface
//
// Behaviour
// - Common commands here act only when they arrive over the GPIB interface.
// - Wait command is valid, does nothing, raises no error.
// - Event enable mask write stores any value 0 to 255.
// - Status byte bit 5 set when any enabled event bit is set.
// - Event enable query returns the mask unchanged.
// - Operation complete command sets event register bit 0.
// - Service enable mask write stores 0 to 255; bits 0,4,5 enable requests.
// - Service enable query returns the mask.
// - Status byte bit 0 set when any enabled measurement condition is set.
// - Status byte bit 4 set while a response waits to be read.
// - Status byte bit 6 carries the master summary status.
// - Status byte query returns bits 0, 4, 5 and 6.
// - Self-test query always answers 0 and does nothing else.
// - Measurement enable mask selects conditions that set status byte bit 0.
// - Measurement enable query returns the mask.
// - Event register read returns contents then clears all bits except those set in the same cycle.
// - Event bit 7 set at power-on and on interface enable.
`timescale 1ns/1ps
`default_nettype none

module gsr_status_core
    import gsr_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    // Decoded command
    input wire logic cmd_valid_in,
    input wire gsr_cmd_e cmd_code_in,
    input wire logic [7:0] cmd_arg_in,
    input wire logic cmd_from_gpib_in,
    // Device events and conditions
    input wire logic query_err_in,
    input wire logic exec_err_in,
    input wire logic cmd_err_in,
    input wire logic [7:0] measurement_condition_register_in,
    input wire logic rsp_waiting_in,
    input wire logic gpib_enabled_in,
    // Command answers
    output logic rsp_valid_out,
    output logic [7:0] rsp_data_out,
    output logic cmd_reject_out,
    // Status
    output logic [7:0] status_byte_out,
    output logic srq_out
);

    ////////////////////////////////////////////////////////////////////////////////
    // Command classification
    function automatic logic is_query(input gsr_cmd_e code);
        is_query = (code == GSR_CMD_ESE_QRY) || (code == GSR_CMD_SRE_QRY) ||
                   (code == GSR_CMD_STB_QRY) || (code == GSR_CMD_TST_QRY) ||
                   (code == GSR_CMD_MCE_QRY) || (code == GSR_CMD_ESR_QRY);
    endfunction

    function automatic logic is_known(input gsr_cmd_e code);
        is_known = is_query(code) || (code == GSR_CMD_WAI) ||
                   (code == GSR_CMD_ESE_SET) || (code == GSR_CMD_OPC) ||
                   (code == GSR_CMD_SRE_SET) || (code == GSR_CMD_MCE_SET);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Registers and wires
    logic [7:0] event_status_enable_mask_r;
    logic [7:0] event_status_enable_mask_nxt;
    logic [7:0] service_request_enable_mask_r;
    logic [7:0] service_request_enable_mask_nxt;
    logic [7:0] measurement_condition_enable_r;
    logic [7:0] measurement_condition_enable_nxt;
    logic gpib_enabled_d_r;
    logic [7:0] event_status_register;
    logic [7:0] esr_set;
    logic esr_clr;
    logic cmd_take;
    logic cmd_ok;
    logic gpib_rise;
    logic [7:0] status_byte_nxt;
    logic master_summary_status;
    logic [7:0] sre_used;
    logic [7:0] rsp_data_nxt;
    logic rsp_valid_nxt;
    logic cmd_reject_nxt;

    ////////////////////////////////////////////////////////////////////////////////
    // Command acceptance
    assign cmd_take = cmd_valid_in && cmd_from_gpib_in;
    assign cmd_ok = cmd_take && is_known(cmd_code_in);
    assign cmd_reject_nxt = cmd_valid_in && !cmd_ok;
    assign rsp_valid_nxt = cmd_ok && is_query(cmd_code_in);

    ////////////////////////////////////////////////////////////////////////////////
    // Enable masks
    assign event_status_enable_mask_nxt =
        (cmd_ok && cmd_code_in == GSR_CMD_ESE_SET) ? cmd_arg_in
                                                    : event_status_enable_mask_r;
    assign service_request_enable_mask_nxt =
        (cmd_ok && cmd_code_in == GSR_CMD_SRE_SET) ? cmd_arg_in
                                                    : service_request_enable_mask_r;
    assign measurement_condition_enable_nxt =
        (cmd_ok && cmd_code_in == GSR_CMD_MCE_SET) ? cmd_arg_in
                                                    : measurement_condition_enable_r;

    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            event_status_enable_mask_r <= ESE_RST;
            service_request_enable_mask_r <= SRE_RST;
            measurement_condition_enable_r <= MCE_RST;
            gpib_enabled_d_r <= 1'b0;
        end
        else
        begin
            event_status_enable_mask_r <= event_status_enable_mask_nxt;
            service_request_enable_mask_r <= service_request_enable_mask_nxt;
            measurement_condition_enable_r <= measurement_condition_enable_nxt;
            gpib_enabled_d_r <= gpib_enabled_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Event status register
    assign gpib_rise = gpib_enabled_in && !gpib_enabled_d_r;
    assign esr_set[ESR_OPC_BIT] = cmd_ok && (cmd_code_in == GSR_CMD_OPC);
    assign esr_set[1] = 1'b0;
    assign esr_set[2] = 1'b0;
    assign esr_set[ESR_QUERY_ERR_BIT] = query_err_in;
    assign esr_set[ESR_EXEC_ERR_BIT] = exec_err_in;
    assign esr_set[ESR_CMD_ERR_BIT] = cmd_err_in;
    assign esr_set[6] = 1'b0;
    assign esr_set[ESR_POWER_ON_BIT] = gpib_rise;
    assign esr_clr = cmd_ok && (cmd_code_in == GSR_CMD_ESR_QRY);

    gsr_event_latch #(
        .RST_VAL(ESR_RST)
    ) u_esr (
        .clk_sys_in(clk_sys_in),
        .sys_rst_in(sys_rst_in),
        .set_in(esr_set),
        .clr_in(esr_clr),
        .bits_out(event_status_register)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Status byte and service request
    assign status_byte_nxt[STB_MEAS_BIT] =
        |(measurement_condition_register_in & measurement_condition_enable_r);
    assign status_byte_nxt[3:1] = 3'h0;
    assign status_byte_nxt[STB_RSP_BIT] = rsp_waiting_in;
    assign status_byte_nxt[STB_EVENT_BIT] =
        |(event_status_register & event_status_enable_mask_r);
    assign status_byte_nxt[STB_MSS_BIT] = master_summary_status;
    assign status_byte_nxt[7] = 1'b0;
    assign sre_used = service_request_enable_mask_r & 8'h31;
    assign master_summary_status =
        |({2'h0, status_byte_nxt[STB_EVENT_BIT], status_byte_nxt[STB_RSP_BIT],
           3'h0, status_byte_nxt[STB_MEAS_BIT]} & sre_used);

    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            status_byte_out <= STB_RST;
            srq_out <= 1'b0;
        end
        else
        begin
            status_byte_out <= status_byte_nxt;
            srq_out <= master_summary_status;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Query answers
    assign rsp_data_nxt =
        (cmd_code_in == GSR_CMD_ESE_QRY) ? event_status_enable_mask_r :
        (cmd_code_in == GSR_CMD_SRE_QRY) ? service_request_enable_mask_r :
        (cmd_code_in == GSR_CMD_MCE_QRY) ? measurement_condition_enable_r :
        (cmd_code_in == GSR_CMD_STB_QRY) ? status_byte_out :
        (cmd_code_in == GSR_CMD_ESR_QRY) ? event_status_register :
        SELF_TEST_RESULT;

    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            rsp_valid_out <= 1'b0;
            rsp_data_out <= RSP_RST;
            cmd_reject_out <= 1'b0;
        end
        else
        begin
            rsp_valid_out <= rsp_valid_nxt;
            cmd_reject_out <= cmd_reject_nxt;
            if (rsp_valid_nxt)
                rsp_data_out <= rsp_data_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (sys_rst_in);

    gpib_only_a: assert property (
        cmd_valid_in && !cmd_from_gpib_in |=> cmd_reject_out && !rsp_valid_out)
        else $error("Command from other interface not refused");

    wai_quiet_a: assert property (
        cmd_take && cmd_code_in == GSR_CMD_WAI |=> !cmd_reject_out && !rsp_valid_out)
        else $error("Wait command answered or refused");

    ese_store_a: assert property (
        cmd_take && cmd_code_in == GSR_CMD_ESE_SET
        |=> event_status_enable_mask_r == $past(cmd_arg_in))
        else $error("Event enable mask not stored");

    event_bit_a: assert property (
        1'b1 |=> status_byte_out[STB_EVENT_BIT] ==
                 $past(|(event_status_register & event_status_enable_mask_r)))
        else $error("Status byte bit 5 wrong");

    ese_query_a: assert property (
        cmd_take && cmd_code_in == GSR_CMD_ESE_QRY |=> rsp_valid_out &&
        rsp_data_out == $past(event_status_enable_mask_r) &&
        event_status_enable_mask_r == $past(event_status_enable_mask_r))
        else $error("Event enable query wrong");

    opc_set_a: assert property (
        cmd_take && cmd_code_in == GSR_CMD_OPC |=> event_status_register[ESR_OPC_BIT])
        else $error("Operation complete bit not set");

    meas_bit_a: assert property (
        1'b1 |=> status_byte_out[STB_MEAS_BIT] == $past(|(measurement_condition_register_in
                                                        & measurement_condition_enable_r)))
        else $error("Status byte bit 0 wrong");

    rsp_bit_a: assert property (
        rsp_waiting_in |=> status_byte_out[STB_RSP_BIT])
        else $error("Status byte bit 4 not set");

    mss_srq_a: assert property (
        1'b1 |=> srq_out == |(status_byte_out & $past(service_request_enable_mask_r) & 8'h31)
                 && status_byte_out[STB_MSS_BIT] == srq_out)
        else $error("Summary or request wrong");

    tst_zero_a: assert property (
        cmd_take && cmd_code_in == GSR_CMD_TST_QRY
        |=> rsp_valid_out && rsp_data_out == SELF_TEST_RESULT)
        else $error("Self-test answer not zero");

    esr_clear_a: assert property (
        cmd_take && cmd_code_in == GSR_CMD_ESR_QRY && esr_set == 8'h00
        |=> rsp_data_out == $past(event_status_register) && event_status_register == 8'h00)
        else $error("Event register read did not clear");

    power_bit_a: assert property (
        gpib_enabled_in && !gpib_enabled_d_r |=> event_status_register[ESR_POWER_ON_BIT])
        else $error("Power-on bit not set on enable");

    srq_raise_c: cover property (
        cmd_take && cmd_code_in == GSR_CMD_SRE_SET ##[1:8] srq_out);
    esr_read_c: cover property (
        cmd_take && cmd_code_in == GSR_CMD_ESR_QRY && esr_set != 8'h00);
    stb_query_c: cover property (
        cmd_take && cmd_code_in == GSR_CMD_STB_QRY ##1 rsp_data_out[STB_MSS_BIT]);

endmodule

`default_nettype wire
